/* File: hw/spi_cfg_pkg.sv */
// constants and types of the serial configuration register bank
package spi_cfg_pkg;
	// register addresses (13-bit address field of the instruction)
	localparam logic [12:0] A_PORT = 13'h000;
	localparam logic [12:0] A_ID = 13'h001;
	localparam logic [12:0] A_GRADE = 13'h002;
	localparam logic [12:0] A_SH_LO = 13'h008;
	localparam logic [12:0] A_SH_HI = 13'h018;
	localparam logic [12:0] A_ORM = 13'h02A;
	localparam logic [12:0] A_XFER = 13'h0FF;
	localparam logic [12:0] A_PART = 13'h101;
	// port configuration layout, nibbles mirrored
	localparam logic [7:0] PORT_FIXED = 8'h18;
	localparam logic [7:0] PORT_LSB = 8'h42;
	localparam logic [7:0] PORT_SOFT = 8'h24;
	// reset values and masks
	localparam logic LSB_RST = 1'h0;
	localparam logic [7:0] ORM_RST = 8'h01;
	localparam logic [7:0] ORM_MASK = 8'h01;
	localparam logic [7:0] PART_RST = 8'h00;
	localparam logic [7:0] SH_RST = 8'h00;
	localparam int XFER_BIT = 0;
	// frame layout
	localparam logic [3:0] INSTR_LAST = 4'hF;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam int RW_BIT = 15;
	// shadow byte indices steering device operation
	localparam logic [4:0] IDX_MODES = 5'h00;
	localparam logic [4:0] IDX_FMT = 5'h0C;
	localparam logic [1:0] PD_FULL = 2'h1;
	typedef enum logic [1:0] {
		PH_INSTR = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ = 2'b10
	} phase_e;
	typedef struct packed {
		phase_e ph;
		logic [3:0] cnt;
		logic [14:0] sh;
		logic [12:0] addr;
	} frame_s;
	typedef struct packed {
		logic cs_n;
		logic pd;
		logic fmt;
	} pins_s;
	typedef logic [16:0][7:0] shadow_t;
endpackage

/* File: hw/spi_config_register_bank.sv */
// serial configuration register bank with shadowed program registers
`timescale 1ns/10ps

// Function
// R1: clock and chip select pins are inputs only
// R2: data pin driven only during readback phase
// R3: pins are static straps when port unused
// R4: board ties chip select high for straps
// R5: strapped data pin high powers chip down
// R6: strapped clock pin high selects twos complement
// R7: eight-bit map, config, program, transfer, part
// R8: out-of-range/mode register resets to 0x01
// R9: master writes zeros into open bits
// R10: master never writes fully open addresses
// R11: reset loads documented register defaults
// R12: 0x08..0x18 writes only reach shadow storage
// R13: writing 0x01 to 0xFF applies all shadows
// R14: transfer bit clears itself after update
// R15: master keeps port idle while sampling
// R16: 16-bit instruction, read flag, byte data
// R17: MSB first by default, LSB first selectable
// R18: unsupported writes ignored, open bits read zero
module spi_config_register_bank #(
	parameter logic [7:0] CHIP_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] GRADE = 8'h00 // speed grade code
)(
	input wire logic clk, // converter-side clock
	input wire logic nrst, // synchronous reset, low active
	input wire logic clock_or_format_pin, // serial clock / strap
	input wire logic chip_select_n, // frame select, low active
	input wire logic data_or_powerdown_pin_in, // data pin level
	output logic data_or_powerdown_pin_out, // data pin drive
	output logic data_or_powerdown_pin_oe, // data pin enable
	output logic chip_power_down, // whole chip powered down
	output logic [1:0] data_format, // 0 offset bin, 1 twos, 2 gray
	output logic mode_pin_out_range, // mode pin acts as overrange
	output spi_cfg_pkg::shadow_t active_cfg // applied program regs
);
	// shadow index from a program register address
	function automatic logic [4:0] sh_idx(input logic [12:0] a);
		sh_idx = 5'(a - spi_cfg_pkg::A_SH_LO);
	endfunction

	function automatic logic is_shadow(input logic [12:0] a);
		is_shadow = (a >= spi_cfg_pkg::A_SH_LO) &&
			(a <= spi_cfg_pkg::A_SH_HI);
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = v[7 - i];
		end
	endfunction

	logic rst_q; // reset held for the link side
	logic link_rst;
	logic frame_rst;
	logic sclk;
	logic din;

	// the serial clock and select are only ever read [R1]
	assign sclk = clock_or_format_pin;
	assign din = data_or_powerdown_pin_in;
	assign link_rst = rst_q;
	// a frame ends by its own select, the clock may stop
	assign frame_rst = link_rst | chip_select_n;

	always_ff @(posedge clk) begin
		rst_q <= !nrst;
	end

	// ---------------- link domain: frame decoding
	spi_cfg_pkg::frame_s fr_q, fr_d;
	logic [15:0] instr;
	logic [7:0] wbyte;
	logic wr_ev;
	logic lsb_q, lsb_d;

	// instruction then bytes, streaming with address increment
	always_comb begin
		instr = {fr_q.sh, din};
		if (lsb_q) begin // [R17]
			instr = {rev8(instr[7:0]), rev8(instr[15:8])};
		end
		wbyte = {fr_q.sh[6:0], din};
		if (lsb_q) begin // [R17]
			wbyte = rev8(wbyte);
		end
		wr_ev = 1'b0;
		fr_d = fr_q;
		fr_d.sh = {fr_q.sh[13:0], din};
		fr_d.cnt = fr_q.cnt + 4'h1;
		unique case (fr_q.ph)
			spi_cfg_pkg::PH_INSTR: begin
				if (fr_q.cnt == spi_cfg_pkg::INSTR_LAST) begin // [R16]
					fr_d.ph = instr[spi_cfg_pkg::RW_BIT] ?
						spi_cfg_pkg::PH_READ : spi_cfg_pkg::PH_WRITE;
					fr_d.addr = instr[12:0];
					fr_d.cnt = 4'h0;
				end
			end
			spi_cfg_pkg::PH_WRITE: begin
				if (fr_q.cnt == spi_cfg_pkg::BYTE_LAST) begin // [R16]
					wr_ev = 1'b1;
					fr_d.addr = fr_q.addr + 13'h1;
					fr_d.cnt = 4'h0;
				end
			end
			spi_cfg_pkg::PH_READ: begin
				if (fr_q.cnt == spi_cfg_pkg::BYTE_LAST) begin
					fr_d.addr = fr_q.addr + 13'h1;
					fr_d.cnt = 4'h0;
				end
			end
			default: begin
				fr_d.ph = spi_cfg_pkg::PH_INSTR;
			end
		endcase
	end

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			fr_q <= '0;
		end else begin
			fr_q <= fr_d;
		end
	end

	// ---------------- link domain: register storage
	spi_cfg_pkg::shadow_t sh_q, sh_d;
	spi_cfg_pkg::shadow_t held_q, held_d;
	logic [7:0] orm_q, orm_d;
	logic [7:0] part_q, part_d;
	logic xtog_q, xtog_d;

	// writes; unknown addresses fall through untouched [R18]
	always_comb begin
		lsb_d = lsb_q;
		sh_d = sh_q;
		held_d = held_q;
		orm_d = orm_q;
		part_d = part_q;
		xtog_d = xtog_q;
		if (wr_ev) begin
			if (fr_q.addr == spi_cfg_pkg::A_PORT) begin
				if ((wbyte & spi_cfg_pkg::PORT_SOFT) != 8'h00) begin
					lsb_d = spi_cfg_pkg::LSB_RST; // [R11]
					sh_d = {17{spi_cfg_pkg::SH_RST}};
					orm_d = spi_cfg_pkg::ORM_RST;
					part_d = spi_cfg_pkg::PART_RST;
				end else begin
					lsb_d = (wbyte & spi_cfg_pkg::PORT_LSB) != 8'h00;
				end
			end else if (is_shadow(fr_q.addr)) begin
				sh_d[sh_idx(fr_q.addr)] = wbyte; // [R12]
			end else if (fr_q.addr == spi_cfg_pkg::A_ORM) begin
				orm_d = wbyte & spi_cfg_pkg::ORM_MASK; // [R18]
			end else if (fr_q.addr == spi_cfg_pkg::A_PART) begin
				part_d = wbyte; // [R7]
			end else if (fr_q.addr == spi_cfg_pkg::A_XFER &&
				wbyte[spi_cfg_pkg::XFER_BIT]) begin
				// snapshot stays still until the next transfer [R13]
				held_d = sh_q;
				xtog_d = !xtog_q; // a toggle, the bit itself is not stored, so it reads back 0 [R14]
			end
		end
	end

	// defaults load on every reset [R11]
	always_ff @(posedge sclk or posedge link_rst) begin
		if (link_rst) begin
			lsb_q <= spi_cfg_pkg::LSB_RST; // [R17]
			sh_q <= {17{spi_cfg_pkg::SH_RST}};
			held_q <= {17{spi_cfg_pkg::SH_RST}};
			orm_q <= spi_cfg_pkg::ORM_RST; // [R8]
			part_q <= spi_cfg_pkg::PART_RST;
			xtog_q <= 1'b0;
		end else begin
			lsb_q <= lsb_d;
			sh_q <= sh_d;
			held_q <= held_d;
			orm_q <= orm_d;
			part_q <= part_d;
			xtog_q <= xtog_d;
		end
	end

	// ---------------- link domain: readback
	logic [7:0] rd_byte;
	logic [2:0] bidx;
	logic out_d, oe_d;

	// open bits and open addresses read as zero [R18]
	always_comb begin
		rd_byte = 8'h00;
		if (fr_q.addr == spi_cfg_pkg::A_PORT) begin
			rd_byte = spi_cfg_pkg::PORT_FIXED |
				(lsb_q ? spi_cfg_pkg::PORT_LSB : 8'h00);
		end else if (fr_q.addr == spi_cfg_pkg::A_ID) begin
			rd_byte = CHIP_ID;
		end else if (fr_q.addr == spi_cfg_pkg::A_GRADE) begin
			rd_byte = GRADE;
		end else if (is_shadow(fr_q.addr)) begin
			rd_byte = sh_q[sh_idx(fr_q.addr)];
		end else if (fr_q.addr == spi_cfg_pkg::A_ORM) begin
			rd_byte = orm_q;
		end else if (fr_q.addr == spi_cfg_pkg::A_PART) begin
			rd_byte = part_q;
		end
	end

	// drive only in the read phase [R2]
	always_comb begin
		bidx = lsb_q ? fr_q.cnt[2:0] : 3'(3'h7 - fr_q.cnt[2:0]);
		oe_d = fr_q.ph == spi_cfg_pkg::PH_READ;
		out_d = oe_d & rd_byte[bidx];
	end

	// launch on the falling edge so the master samples on rising
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			data_or_powerdown_pin_out <= 1'b0;
			data_or_powerdown_pin_oe <= 1'b0;
		end else begin
			data_or_powerdown_pin_out <= out_d;
			data_or_powerdown_pin_oe <= oe_d;
		end
	end

	// ---------------- converter domain
	spi_cfg_pkg::pins_s pins_now, ps1_q, ps2_q;
	spi_cfg_pkg::pins_s strap_q, strap_d;
	logic done_q, done_d;
	logic [2:0] xs_q;
	logic [1:0] om_q;
	spi_cfg_pkg::shadow_t act_q, act_d;
	logic pd_q, pd_d;
	logic [1:0] fmt_q, fmt_d;

	assign pins_now = '{cs_n: chip_select_n, pd: din, fmt: sclk};

	// two-stage synchronisers; xs_q[2] only serves edge detect
	always_ff @(posedge clk) begin
		ps1_q <= pins_now;
		ps2_q <= ps1_q;
		if (!nrst) begin
			xs_q <= 3'h0;
			om_q <= 2'h0;
		end else begin
			xs_q <= {xs_q[1:0], xtog_q};
			om_q <= {om_q[0], orm_q[0]};
		end
	end

	// straps caught once after release; shadows applied at once
	always_comb begin
		strap_d = strap_q;
		done_d = 1'b1;
		if (!done_q) begin
			strap_d = ps2_q; // [R3]
		end
		act_d = act_q;
		if (xs_q[2] ^ xs_q[1]) begin
			act_d = held_q; // [R13]
		end
		if (strap_q.cs_n) begin
			pd_d = strap_q.pd; // [R5]
			fmt_d = {1'b0, strap_q.fmt}; // [R6]
		end else begin
			pd_d = act_q[spi_cfg_pkg::IDX_MODES][1:0] ==
				spi_cfg_pkg::PD_FULL;
			fmt_d = act_q[spi_cfg_pkg::IDX_FMT][1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			strap_q <= '0;
			done_q <= 1'b0;
			act_q <= {17{spi_cfg_pkg::SH_RST}};
			pd_q <= 1'b0;
			fmt_q <= 2'h0;
		end else begin
			strap_q <= strap_d;
			done_q <= done_d;
			act_q <= act_d;
			pd_q <= pd_d;
			fmt_q <= fmt_d;
		end
	end

	assign chip_power_down = pd_q;
	assign data_format = fmt_q;
	assign mode_pin_out_range = om_q[1]; // [R8]
	assign active_cfg = act_q;

	// ---------------- checks
	sequence xfer_wr_s;
		wr_ev && fr_q.addr == spi_cfg_pkg::A_XFER && wbyte[0];
	endsequence

	sequence xfer_seen_s;
		xs_q[2] ^ xs_q[1];
	endsequence

	xfer_toggle_a: assert property ( // [R14]
		@(posedge sclk) disable iff (link_rst)
		xfer_wr_s |=> xtog_q != $past(xtog_q) && held_q == $past(sh_q))
		else $error("transfer write did not hand over");

	shadow_hold_a: assert property ( // [R12]
		@(posedge sclk) disable iff (link_rst)
		wr_ev && is_shadow(fr_q.addr) |=> $stable(held_q))
		else $error("shadow write reached applied copy");

	xfer_apply_a: assert property ( // [R13]
		@(posedge clk) disable iff (!nrst)
		xfer_seen_s |=> act_q == held_q)
		else $error("transfer not applied");

	active_still_a: assert property ( // [R12]
		@(posedge clk) disable iff (!nrst)
		!(xs_q[2] ^ xs_q[1]) |=> $stable(act_q))
		else $error("applied registers moved without transfer");

	open_write_a: assert property ( // [R18]
		@(posedge sclk) disable iff (link_rst)
		wr_ev && (fr_q.addr == spi_cfg_pkg::A_ID ||
		fr_q.addr == spi_cfg_pkg::A_GRADE) |=>
		$stable(sh_q) && $stable(orm_q) && $stable(part_q))
		else $error("read-only write changed state");

	instr_len_a: assert property ( // [R16]
		@(posedge sclk) disable iff (frame_rst)
		fr_q.ph == spi_cfg_pkg::PH_INSTR &&
		fr_q.cnt != spi_cfg_pkg::INSTR_LAST |=>
		fr_q.ph == spi_cfg_pkg::PH_INSTR)
		else $error("instruction phase ended early");

	drive_dir_a: assert property ( // [R2]
		@(negedge sclk) disable iff (frame_rst)
		fr_q.ph != spi_cfg_pkg::PH_READ |=>
		!data_or_powerdown_pin_oe)
		else $error("data pin driven outside readback");

	strap_pd_a: assert property ( // [R5]
		@(posedge clk) disable iff (!nrst)
		strap_q.cs_n ##1 strap_q.cs_n |->
		chip_power_down == $past(strap_q.pd))
		else $error("strap power-down not followed");

	strap_fmt_a: assert property ( // [R6]
		@(posedge clk) disable iff (!nrst)
		strap_q.cs_n ##1 strap_q.cs_n |->
		data_format == {1'b0, $past(strap_q.fmt)})
		else $error("strap format not followed");

	orm_reset_a: assert property ( // [R8]
		@(posedge clk) disable iff (!nrst)
		$fell(rst_q) |-> orm_q == spi_cfg_pkg::ORM_RST)
		else $error("mode register default wrong");
endmodule

/* File: testbench/spi_config_register_bank_tb.sv */
// self-checking bench of the serial configuration register bank
`timescale 1ns/10ps
module spi_config_register_bank_tb;
	logic clk, nrst, sclk, cs_n, mosi, pin_out, pin_oe, pd, omr;
	logic [1:0] fmt;
	logic [7:0] q, v;
	logic [4:0] k;
	logic [31:0] seed;
	spi_cfg_pkg::shadow_t act, sh_e, act_e;
	int n_mismatch, checks, n_bad, cyc;
	wire pin = pin_oe ? pin_out : mosi;

	spi_config_register_bank #(.CHIP_ID(8'h3C)) dut_u ( // arbitrary id
		.clk(clk), .nrst(nrst), .clock_or_format_pin(sclk),
		.chip_select_n(cs_n), .data_or_powerdown_pin_in(pin),
		.data_or_powerdown_pin_out(pin_out),
		.data_or_powerdown_pin_oe(pin_oe), .chip_power_down(pd),
		.data_format(fmt), .mode_pin_out_range(omr), .active_cfg(act));

	spi_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(pin), .dev_oe(pin_oe), .n_bad(n_bad));

	// converter clock, 40 ns
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			$display("mismatch at %0t: timeout", $time);
			stop_test();
		end
	end

	// xorshift source, low byte used
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// expected power-down and format from applied program bytes
	function automatic logic [7:0] exp_run(spi_cfg_pkg::shadow_t s);
		logic p;
		p = s[spi_cfg_pkg::IDX_MODES][1:0] == spi_cfg_pkg::PD_FULL;
		return {5'h00, p, s[spi_cfg_pkg::IDX_FMT][1:0]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// pins settle before reset so straps are stable at capture
	task automatic rst(input logic s, input logic c, input logic d);
		host_u.pins(s, c, d);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic stop_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		seed = 32'h0000D2E2; // 53986
		// every strap combination with the port off
		for (int i = 0; i < 4; i++) begin
			rst(1'b1, i[0], i[1]);
			chk({6'h00, fmt}, {7'h00, i[0]});
			chk({7'h00, pd}, {7'h00, i[1]});
		end
		$display("strap test done");
		rst(1'b0, 1'b0, 1'b0);
		host_u.pins(1'b1, 1'b0, 1'b0);
		#64;
		for (int i = 0; i < 17; i++)
			chk(act[i], spi_cfg_pkg::SH_RST);
		chk({5'h00, pd, fmt}, exp_run('0));
		chk({7'h00, omr}, 8'h01);
		host_u.xfer(1'b1, spi_cfg_pkg::A_PORT, 8'h00, q);
		chk(q, spi_cfg_pkg::PORT_FIXED);
		host_u.xfer(1'b1, spi_cfg_pkg::A_ORM, 8'h00, q);
		chk(q, spi_cfg_pkg::ORM_RST);
		// read-only places keep their value, an unsupported one reads zero
		host_u.xfer(1'b0, spi_cfg_pkg::A_ID, 8'hC3, q);
		host_u.xfer(1'b1, spi_cfg_pkg::A_ID, 8'h00, q);
		chk(q, 8'h3C);
		host_u.xfer(1'b0, spi_cfg_pkg::A_GRADE, rnd(), q);
		host_u.xfer(1'b1, spi_cfg_pkg::A_GRADE, 8'h00, q);
		chk(q, 8'h00);
		host_u.xfer(1'b1, 13'h020, 8'h00, q);
		chk(q, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = rnd() & spi_cfg_pkg::ORM_MASK;
			host_u.xfer(1'b0, spi_cfg_pkg::A_ORM, v, q);
			host_u.xfer(1'b1, spi_cfg_pkg::A_ORM, 8'h00, q);
			chk(q, v);
			repeat (4) @(posedge clk);
			chk({7'h00, omr}, v);
		end
		// part register through lsb-first shifting
		host_u.xfer(1'b0, spi_cfg_pkg::A_PORT,
			spi_cfg_pkg::PORT_LSB, q);
		host_u.lsb = 1'b1;
		host_u.xfer(1'b1, spi_cfg_pkg::A_PORT, 8'h00, q);
		chk(q, spi_cfg_pkg::PORT_FIXED | spi_cfg_pkg::PORT_LSB);
		v = rnd();
		host_u.xfer(1'b0, spi_cfg_pkg::A_PART, v, q);
		host_u.xfer(1'b1, spi_cfg_pkg::A_PART, 8'h00, q);
		chk(q, v);
		host_u.xfer(1'b0, spi_cfg_pkg::A_PORT, 8'h00, q);
		host_u.lsb = 1'b0;
		host_u.xfer(1'b1, spi_cfg_pkg::A_PART, 8'h00, q);
		chk(q, v);
		// soft reset brings the defaults back
		host_u.xfer(1'b0, spi_cfg_pkg::A_PORT,
			spi_cfg_pkg::PORT_SOFT, q);
		host_u.xfer(1'b1, spi_cfg_pkg::A_PART, 8'h00, q);
		chk(q, spi_cfg_pkg::PART_RST);
		host_u.xfer(1'b1, spi_cfg_pkg::A_ORM, 8'h00, q);
		chk(q, spi_cfg_pkg::ORM_RST);
		host_u.xfer(1'b1, spi_cfg_pkg::A_PORT, 8'h00, q);
		chk(q, spi_cfg_pkg::PORT_FIXED);
		$display("register test done");
		// random shadow writes, applied only by the transfer command
		sh_e = '0;
		act_e = '0;
		for (int r = 0; r < 4; r++) begin
			for (int i = 0; i < 6; i++) begin
				v = rnd();
				k = v[4] ? 5'h10 : {1'b0, v[3:0]};
				// 0x13 is a wholly open location, never written
				if (k == 5'h0B) k = 5'h0C;
				v = rnd();
				host_u.xfer(1'b0, spi_cfg_pkg::A_SH_LO + 13'(k), v, q);
				sh_e[k] = v;
			end
			repeat (8) @(posedge clk);
			for (int i = 0; i < 17; i++) chk(act[i], act_e[i]);
			host_u.xfer(1'b0, spi_cfg_pkg::A_XFER, 8'h01, q);
			act_e = sh_e;
			repeat (8) @(posedge clk);
			for (int i = 0; i < 17; i++) chk(act[i], act_e[i]);
			chk({5'h00, pd, fmt}, exp_run(act_e));
			host_u.xfer(1'b1, spi_cfg_pkg::A_XFER, 8'h00, q);
			chk(q, 8'h00);
		end
		chk(8'(n_bad), 8'h00);
		$display("shadow test done");
		stop_test();
	end
endmodule

/* File: testbench/spi_host_model.sv */
// serial port master model driving the three-wire configuration port
`timescale 1ns/10ps
module spi_host_model (
	output logic sclk, // serial clock, still low between frames
	output logic cs_n, // frame select, low active
	output logic mosi, // master drive level of the data wire
	input wire logic miso, // resolved data wire level
	input wire logic dev_oe, // device drives the data wire
	output int n_bad // device drives while the master owns the wire
);
	logic lsb; // shift order of the frames, set by the bench

	// idle port keeps converter sampling quiet
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		n_bad = 0;
		lsb = 1'b0;
	end

	// static pin levels; chip select high turns the port off
	task automatic pins(input logic s, input logic c, input logic d);
		cs_n = s;
		sclk = c;
		mosi = d;
	endtask

	// one frame: 16-bit instruction then one byte, msb first unless lsb is set
	// open addresses are never written by this model
	task automatic xfer(input logic rd, input logic [12:0] a,
		input logic [7:0] wd, output logic [7:0] q);
		logic [23:0] f, g;
		logic [7:0] r;
		g = {rd, 2'h0, a, wd};
		f = g;
		// lsb first reverses the whole instruction and each byte
		if (lsb) begin
			for (int j = 0; j < 16; j++) f[8 + j] = g[23 - j];
			for (int j = 0; j < 8; j++) f[j] = g[7 - j];
		end
		q = 8'h00;
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			// released wire toggles so a stale level never reads back
			if (rd && i < 8) mosi = ~mosi;
			else mosi = f[i];
			#16 sclk = 1'b1;
			if (i < 8) q[i] = miso;
			if (dev_oe && !(rd && i < 8)) n_bad++;
			#16 sclk = 1'b0;
		end
		cs_n = 1'b1;
		r = q;
		if (lsb) begin
			for (int j = 0; j < 8; j++) q[j] = r[7 - j];
		end
		#64;
	endtask
endmodule
